// >>> design/lineif_pkg.sv
// Behaviour
// - Upper summary location shows pending flags of channels 11..6 in bits 5..0.
// - Lower summary location shows pending flags of channels 5..0 in bits 5..0.
// - A pending flag reads 1 while any interrupt of its channel awaits service.
// - A set pending flag stays set until that channel's event flags are read.
// - Part identifier register always returns one fixed value; writes ignored.
// - Revision register reads zero in bits 7..4 and the revision in bits 3..0.
// - Decode serves nine registers for each of the twelve channels.
// - Channel pages hold registers at offsets 1-6 and A-C; pages 0-5, 8-D.
// - Pages 6 and E hold master enables and summaries; 6 also identity words.
// - A cleared channel master enable keeps that channel off the interrupt pin.
// - Enabled lock-loss, no-signal and drive-monitor changes raise channel events.
package lineif_pkg;

    // ==============================================================
    // Geometry
    localparam int       NUM_CH       = 12;
    localparam int       HALF_CH      = 6;
    localparam int       SRC_W        = 3;
    localparam int       ADDR_W       = 8;
    localparam int       DATA_W       = 8;

    // ==============================================================
    // Source field positions
    localparam int       BIT_LOCK     = 2;
    localparam int       BIT_NOSIG    = 1;
    localparam int       BIT_DRIVE    = 0;

    // ==============================================================
    // Pages
    localparam bit [3:0] PAGE_HI_BASE = 4'h8;
    localparam bit [3:0] PAGE_LAST_LO = 4'h5;
    localparam bit [3:0] PAGE_LAST_HI = 4'hD;
    localparam bit [3:0] PAGE_GLB_LO  = 4'h6;
    localparam bit [3:0] PAGE_GLB_HI  = 4'hE;
    localparam bit [3:0] PAGE_PROT_LO = 4'h0;
    localparam bit [3:0] PAGE_PROT_HI = 4'h8;

    // ==============================================================
    // Offsets within a page
    localparam bit [3:0] OFF_SRC_EN   = 4'h1;
    localparam bit [3:0] OFF_SRC_FLG  = 4'h2;
    localparam bit [3:0] OFF_ALARM    = 4'h3;
    localparam bit [3:0] OFF_TX_CTL   = 4'h4;
    localparam bit [3:0] OFF_RX_CFG   = 4'h5;
    localparam bit [3:0] OFF_CH_CTL   = 4'h6;
    localparam bit [3:0] OFF_EXT_A    = 4'hA;
    localparam bit [3:0] OFF_EXT_B    = 4'hB;
    localparam bit [3:0] OFF_EXT_C    = 4'hC;
    localparam bit [3:0] OFF_PROT_TX  = 4'h0;
    localparam bit [3:0] OFF_PROT_RX  = 4'h8;
    localparam bit [3:0] OFF_MASTER   = 4'h0;
    localparam bit [3:0] OFF_SUMMARY  = 4'h1;
    localparam bit [3:0] OFF_PART     = 4'hE;
    localparam bit [3:0] OFF_REV      = 4'hF;

    // ==============================================================
    // Full addresses of the global words
    localparam bit [7:0] ADDR_PEND_LO = 8'h61;
    localparam bit [7:0] ADDR_PEND_HI = 8'hE1;
    localparam bit [7:0] ADDR_PART    = 8'h6E;
    localparam bit [7:0] ADDR_REV     = 8'h6F;

    // ==============================================================
    // Reset values
    localparam bit [7:0] RST_BYTE     = 8'h00;

endpackage

// >>> design/lineif_store.sv
`timescale 1ns/1ns
module lineif_store #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          mclk_in,
    input  wire logic          rst_b_in,
    input  wire logic          ce_in,
    // Write side
    input  wire logic          we_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [DW-1:0] wdata_in,
    // Read side
    input  wire logic          re_in,
    input  wire logic [AW-1:0] raddr_in,
    output logic      [DW-1:0] rdata_out
);

    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0]              q;
    } store_state_t;

    store_state_t st_ff;
    store_state_t nxt_st;

    // ==============================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        if (re_in) begin
            nxt_st.q = st_ff.mem[raddr_in];
        end
        if (we_in) begin
            nxt_st.mem[waddr_in] = wdata_in;
        end
    end

    // Zeroed at reset so that unwritten words read a known value
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_out = st_ff.q;

endmodule

// >>> design/lineif_irq_summary_and_map.sv
`timescale 1ns/1ns
module lineif_irq_summary_and_map #(
    parameter logic [7:0] PART_ID_VAL  = 8'h5A,  // Arbitrary value
    parameter logic [3:0] REVISION_VAL = 4'h3    // Arbitrary value
) (
    // Clock, reset, enable
    input  wire logic                         mclk_in,
    input  wire logic                         rst_b_in,
    input  wire logic                         ce_in,
    // Host parallel bus
    input  wire logic                         cs_b_in,
    input  wire logic                         rd_b_in,
    input  wire logic                         wr_b_in,
    input  wire logic [lineif_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [lineif_pkg::DATA_W-1:0] wdata_in,
    output logic      [lineif_pkg::DATA_W-1:0] rdata_out,
    output logic                              rdy_out,
    output logic                              int_b_out,
    // Line-side conditions
    input  wire logic [lineif_pkg::NUM_CH-1:0] lock_loss_in,
    input  wire logic [lineif_pkg::NUM_CH-1:0] no_signal_alarm_in,
    input  wire logic [lineif_pkg::NUM_CH-1:0] drive_monitor_flag_in,
    // Per-channel summary
    output logic      [lineif_pkg::NUM_CH-1:0] chan_pending_out
);

    localparam int NC = lineif_pkg::NUM_CH;
    localparam int SW = lineif_pkg::SRC_W;
    localparam int HC = lineif_pkg::HALF_CH;

    typedef struct packed {
        logic [NC-1:0]          master_en;
        logic [NC-1:0][SW-1:0]  src_en;
        logic [NC-1:0][SW-1:0]  flags;
        logic [NC-1:0]          prev_lock;
        logic [NC-1:0]          prev_nosig;
        logic [NC-1:0]          prev_drive;
        logic                   primed;
        logic [7:0]             rdata;
        logic                   mem_sel;
        logic                   rdy;
        logic                   irq;
    } lineif_state_t;

    lineif_state_t st_ff;
    lineif_state_t nxt_st;

    // ==============================================================
    // Decode helpers
    // Returns {valid, channel index} for a channel page
    function automatic logic [4:0] chan_decode(input logic [3:0] page);
        logic [4:0] r;
        r = 5'h00;
        if (page <= lineif_pkg::PAGE_LAST_LO) begin
            r = {1'b1, page};
        end else if (page >= lineif_pkg::PAGE_HI_BASE && page <= lineif_pkg::PAGE_LAST_HI) begin
            r = {1'b1, page - lineif_pkg::PAGE_HI_BASE + 4'(HC)};
        end
        return r;
    endfunction

    // Plain storage words kept in the memory
    function automatic logic is_storage(input logic [7:0] a);
        logic [4:0] cd;
        logic [3:0] off;
        logic       hit;
        cd  = chan_decode(a[7:4]);
        off = a[3:0];
        hit = cd[4] && (off == lineif_pkg::OFF_TX_CTL || off == lineif_pkg::OFF_RX_CFG
              || off == lineif_pkg::OFF_CH_CTL || off == lineif_pkg::OFF_EXT_A
              || off == lineif_pkg::OFF_EXT_B || off == lineif_pkg::OFF_EXT_C);
        if ((a[7:4] == lineif_pkg::PAGE_PROT_LO || a[7:4] == lineif_pkg::PAGE_PROT_HI)
            && (off == lineif_pkg::OFF_PROT_TX || off == lineif_pkg::OFF_PROT_RX)) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    function automatic logic [NC-1:0] pend_of(input logic [NC-1:0][SW-1:0] f);
        logic [NC-1:0] p;
        p = '0;
        for (int c = 0; c < NC; c++) begin
            p[c] = |f[c];
        end
        return p;
    endfunction

    // ==============================================================
    // Bus strobes; a write wins over a read in the same cycle
    logic       wr_take;
    logic       rd_take;
    logic [3:0] page;
    logic [3:0] off;
    logic [4:0] cdec;
    logic [3:0] cidx;
    logic [7:0] mem_q;

    assign wr_take = ce_in && !cs_b_in && !wr_b_in;
    assign rd_take = ce_in && !cs_b_in && !rd_b_in && wr_b_in;
    assign page    = addr_in[7:4];
    assign off     = addr_in[3:0];
    assign cdec    = chan_decode(page);
    assign cidx    = cdec[3:0];

    // Helper masks, also watched by the checks below
    logic [NC-1:0][SW-1:0] evt;
    logic [NC-1:0]         clr_mask;
    logic [NC-1:0]         pend_now;

    assign pend_now = pend_of(st_ff.flags);

    always_comb begin
        for (int c = 0; c < NC; c++) begin
            evt[c] = '0;
            // First cycle after reset only samples, no false change
            if (st_ff.primed) begin
                evt[c][lineif_pkg::BIT_LOCK]  = lock_loss_in[c] ^ st_ff.prev_lock[c];
                evt[c][lineif_pkg::BIT_NOSIG] = no_signal_alarm_in[c] ^ st_ff.prev_nosig[c];
                evt[c][lineif_pkg::BIT_DRIVE] = drive_monitor_flag_in[c] ^ st_ff.prev_drive[c];
            end
            evt[c]      = evt[c] & st_ff.src_en[c];
            clr_mask[c] = rd_take && cdec[4] && cidx == 4'(c) && off == lineif_pkg::OFF_SRC_FLG;
        end
    end

    // ==============================================================
    // Next state
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.rdy     = rd_take;
        nxt_st.mem_sel = rd_take && is_storage(addr_in);
        nxt_st.primed  = 1'b1;
        nxt_st.prev_lock  = lock_loss_in;
        nxt_st.prev_nosig = no_signal_alarm_in;
        nxt_st.prev_drive = drive_monitor_flag_in;

        // Clear on read of event flags; a new event in that cycle wins
        for (int c = 0; c < NC; c++) begin
            nxt_st.flags[c] = (clr_mask[c] ? '0 : st_ff.flags[c]) | evt[c];
        end

        if (wr_take) begin
            if (cdec[4] && off == lineif_pkg::OFF_SRC_EN) begin
                nxt_st.src_en[cidx] = wdata_in[SW-1:0];
            end
            if (off == lineif_pkg::OFF_MASTER && page == lineif_pkg::PAGE_GLB_LO) begin
                nxt_st.master_en[HC-1:0] = wdata_in[HC-1:0];
            end
            if (off == lineif_pkg::OFF_MASTER && page == lineif_pkg::PAGE_GLB_HI) begin
                nxt_st.master_en[NC-1:HC] = wdata_in[HC-1:0];
            end
        end

        if (rd_take) begin
            nxt_st.rdata = lineif_pkg::RST_BYTE;
            if (cdec[4]) begin
                unique case (off)
                    lineif_pkg::OFF_SRC_EN:
                        nxt_st.rdata = {5'h00, st_ff.src_en[cidx]};
                    lineif_pkg::OFF_SRC_FLG:
                        nxt_st.rdata = {5'h00, st_ff.flags[cidx]};
                    lineif_pkg::OFF_ALARM: begin
                        nxt_st.rdata[lineif_pkg::BIT_LOCK]  = lock_loss_in[cidx];
                        nxt_st.rdata[lineif_pkg::BIT_NOSIG] = no_signal_alarm_in[cidx];
                        nxt_st.rdata[lineif_pkg::BIT_DRIVE] = drive_monitor_flag_in[cidx];
                    end
                    default: nxt_st.rdata = lineif_pkg::RST_BYTE;
                endcase
            end
            unique case (addr_in)
                {lineif_pkg::PAGE_GLB_LO, lineif_pkg::OFF_MASTER}:
                    nxt_st.rdata = {2'b00, st_ff.master_en[HC-1:0]};
                {lineif_pkg::PAGE_GLB_HI, lineif_pkg::OFF_MASTER}:
                    nxt_st.rdata = {2'b00, st_ff.master_en[NC-1:HC]};
                lineif_pkg::ADDR_PEND_LO:
                    nxt_st.rdata = {2'b00, pend_now[HC-1:0]};
                lineif_pkg::ADDR_PEND_HI:
                    nxt_st.rdata = {2'b00, pend_now[NC-1:HC]};
                lineif_pkg::ADDR_PART:
                    nxt_st.rdata = PART_ID_VAL;
                lineif_pkg::ADDR_REV:
                    nxt_st.rdata = {4'h0, REVISION_VAL};
                default: ;
            endcase
        end

        // Registered so the pin never glitches on decode
        nxt_st.irq = |(pend_of(nxt_st.flags) & nxt_st.master_en);
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    // ==============================================================
    // Storage words
    lineif_store #(
        .AW (lineif_pkg::ADDR_W),
        .DW (lineif_pkg::DATA_W)
    ) u_store (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .ce_in     (ce_in),
        .we_in     (wr_take && is_storage(addr_in)),
        .waddr_in  (addr_in),
        .wdata_in  (wdata_in),
        .re_in     (rd_take && is_storage(addr_in)),
        .raddr_in  (addr_in),
        .rdata_out (mem_q)
    );

    // ==============================================================
    // Outputs
    assign rdata_out        = st_ff.mem_sel ? mem_q : st_ff.rdata;
    assign rdy_out          = st_ff.rdy;
    assign int_b_out        = !st_ff.irq;
    assign chan_pending_out = pend_of(st_ff.flags);

    // ==============================================================
    // Checks
    AST_PART_ID: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && addr_in == lineif_pkg::ADDR_PART |=> rdata_out == PART_ID_VAL)
        else $error("Part identifier read wrong");

    AST_REV_UPPER: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && addr_in == lineif_pkg::ADDR_REV |=> rdata_out == {4'h0, REVISION_VAL})
        else $error("Revision read wrong");

    AST_SUMMARY_HI: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && addr_in == lineif_pkg::ADDR_PEND_HI
        |=> rdata_out == {2'b00, $past(chan_pending_out[NC-1:HC])})
        else $error("Upper summary wrong");

    AST_SUMMARY_LO: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && addr_in == lineif_pkg::ADDR_PEND_LO
        |=> rdata_out == {2'b00, $past(chan_pending_out[HC-1:0])})
        else $error("Lower summary wrong");

    AST_PEND_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ce_in |=> (($past(chan_pending_out) & ~$past(clr_mask)) & ~chan_pending_out) == '0)
        else $error("Pending flag dropped without a read");

    AST_EVENT_SET: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ce_in && |evt |=> (st_ff.flags & $past(evt)) == $past(evt))
        else $error("Enabled change not flagged");

    AST_MASTER_GATE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !int_b_out |-> |(chan_pending_out & st_ff.master_en))
        else $error("Interrupt pin without enabled pending channel");

    AST_UNMAPPED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && (page == 4'h7 || page == 4'hF) |=> rdata_out == 8'h00 ##0 rdy_out)
        else $error("Unmapped read not zero");

    COV_IRQ: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        int_b_out ##1 !int_b_out);
    COV_CLEAR: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        |clr_mask ##1 int_b_out);
    COV_SET_WINS: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        |(clr_mask & pend_of(evt)));
    COV_MASKED: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        |(chan_pending_out & ~st_ff.master_en));
    COV_HI_READ: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && addr_in == lineif_pkg::ADDR_PEND_HI && |chan_pending_out[NC-1:HC]);

    // ==============================================================
    // Checks on enables, clearing and live words
    // New flag bits may only come from sources enabled a cycle earlier
    AST_SRC_DISABLED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ce_in |=> (st_ff.flags & ~$past(st_ff.flags) & ~$past(st_ff.src_en)) == '0)
        else $error("Flag set by a disabled source");

    // A quiet channel must drop its pending bit at the read's answer edge
    AST_CLEAR_ON_READ: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && cdec[4] && off == lineif_pkg::OFF_SRC_FLG && evt[cidx] == '0
        |=> chan_pending_out[$past(cidx)] == 1'b0)
        else $error("Pending flag kept after its event flags were read");

    AST_SRC_EN_READ: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && cdec[4] && off == lineif_pkg::OFF_SRC_EN
        |=> rdata_out == {5'h00, $past(st_ff.src_en[cidx])})
        else $error("Source enable read wrong");

    // Alarm words are live levels, so they match the inputs of the taking edge
    AST_ALARM_LIVE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        rd_take && cdec[4] && off == lineif_pkg::OFF_ALARM
        |=> rdata_out == {5'h00, $past(lock_loss_in[cidx]), $past(no_signal_alarm_in[cidx]),
                          $past(drive_monitor_flag_in[cidx])})
        else $error("Alarm read wrong");

    AST_MASTER_WRITE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        wr_take && addr_in == {lineif_pkg::PAGE_GLB_LO, lineif_pkg::OFF_MASTER}
        |=> st_ff.master_en[HC-1:0] == $past(wdata_in[HC-1:0]))
        else $error("Lower master enable write lost");

    // Read-only words must leave every enable untouched when written
    AST_RO_WRITE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        wr_take && (addr_in == lineif_pkg::ADDR_PART || addr_in == lineif_pkg::ADDR_REV
            || addr_in == lineif_pkg::ADDR_PEND_LO || addr_in == lineif_pkg::ADDR_PEND_HI)
        |=> st_ff.master_en == $past(st_ff.master_en) && st_ff.src_en == $past(st_ff.src_en))
        else $error("Write to a read-only word changed state");

endmodule

// >>> tb/lineif_host_model.sv
`timescale 1ns/1ns
module lineif_host_model (
    // Clock
    input  wire logic                          mclk_in,
    // Host bus
    output logic                               cs_b_out,
    output logic                               rd_b_out,
    output logic                               wr_b_out,
    output logic [lineif_pkg::ADDR_W-1:0]      addr_out,
    output logic [lineif_pkg::DATA_W-1:0]      wdata_out
);
    initial begin
        cs_b_out  = 1'b1;
        rd_b_out  = 1'b1;
        wr_b_out  = 1'b1;
        addr_out  = 8'h00;
        wdata_out = 8'h00;
    end

    // ==============================================================
    // One access
    // Strobe lasts one edge only: a longer hold is taken as repeated reads
    task automatic do_access(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        cs_b_out  <= 1'b0;
        rd_b_out  <= ~rd;
        wr_b_out  <= rd;
        addr_out  <= a;
        wdata_out <= d;
        @(posedge mclk_in);
        cs_b_out  <= 1'b1;
        rd_b_out  <= 1'b1;
        wr_b_out  <= 1'b1;
        // Released bus shows the inverse, never the last value
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask
endmodule

// >>> tb/lineif_irq_summary_and_map_tb_top.sv
`timescale 1ns/1ns
module lineif_irq_summary_and_map_tb_top;
    localparam logic [7:0] PART_V = 8'h3C;  // Arbitrary value
    localparam logic [3:0] REV_V  = 4'h9;   // Arbitrary value

    logic        mclk_in  = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        ce       = 1'b1;
    logic        cs_b, rd_b, wr_b, rdy, int_b;
    logic [7:0]  addr, wdata, rdata, d;
    logic [11:0] lock, nosig, drive, pend;
    logic [7:0]  exp_q[$];
    logic [7:0]  lst[$];
    int          fail_count = 0;
    int          checked    = 0;
    int          cycles     = 0;
    integer      seed       = 32'h8a5e_e4a6;

    always #2 mclk_in = ~mclk_in;

    initial begin
        lock  = 12'($random(seed));
        nosig = 12'($random(seed));
        drive = 12'($random(seed));
    end

    lineif_host_model host_u (.mclk_in(mclk_in), .cs_b_out(cs_b), .rd_b_out(rd_b),
        .wr_b_out(wr_b), .addr_out(addr), .wdata_out(wdata));

    lineif_irq_summary_and_map #(.PART_ID_VAL(PART_V), .REVISION_VAL(REV_V)) dut_u (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce), .cs_b_in(cs_b),
        .rd_b_in(rd_b), .wr_b_in(wr_b), .addr_in(addr), .wdata_in(wdata),
        .rdata_out(rdata), .rdy_out(rdy), .int_b_out(int_b), .lock_loss_in(lock),
        .no_signal_alarm_in(nosig), .drive_monitor_flag_in(drive), .chan_pending_out(pend));

    // ==============================================================
    // Helpers
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.do_access(1'b1, a, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host_u.do_access(1'b0, a, v);
    endtask

    function automatic logic [7:0] ca(input int c, input logic [3:0] off);
        return {(c < 6) ? 4'(c) : 4'(c + 2), off};
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    // ==============================================================
    // Read answer watcher
    always @(negedge mclk_in) begin
        if (rdy === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected answer", 12'h001, 12'h000);
            else check("read data", {4'h0, rdata}, {4'h0, exp_q.pop_front()});
        end
    end

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("timeout");
            finish_test();
        end
    end

    // ==============================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        @(negedge mclk_in);
        check("int after reset", {11'h0, int_b}, 12'h001);
        check("pending after reset", pend, 12'h000);
        // Identity and read-only words
        wr(8'h6E, 8'hFF);
        wr(8'h6F, 8'hFF);
        wr(8'h61, 8'hFF);
        wr(8'hE1, 8'hFF);
        rd(8'h6E, PART_V);
        rd(8'h6F, {4'h0, REV_V});
        rd(8'h61, 8'h00);
        rd(8'hE1, 8'h00);
        lst = '{8'h07, 8'h09, 8'h0D, 8'h62, 8'h6D, 8'h70, 8'h7F, 8'hE2, 8'hF0, 8'h1E};
        foreach (lst[i]) begin
            wr(lst[i], 8'hFF);
            rd(lst[i], 8'h00);
        end
        $display("test done: identity and unmapped");
        // Storage and enables over every channel page
        lst = '{8'h4, 8'h5, 8'h6, 8'hA, 8'hB, 8'hC};
        for (int c = 0; c < 12; c++) begin
            foreach (lst[i]) begin
                d = 8'($random(seed));
                wr(ca(c, lst[i][3:0]), d);
                rd(ca(c, lst[i][3:0]), d);
            end
            wr(ca(c, 4'h1), 8'hFF);
            rd(ca(c, 4'h1), 8'h07);
        end
        lst = '{8'h00, 8'h08, 8'h80, 8'h88};
        foreach (lst[i]) begin
            d = 8'($random(seed));
            wr(lst[i], d);
            rd(lst[i], d);
        end
        wr(8'h60, 8'hFF);
        wr(8'hE0, 8'hFF);
        rd(8'h60, 8'h3F);
        rd(8'hE0, 8'h3F);
        $display("test done: storage");
        // Every source of every channel, both directions
        for (int c = 0; c < 12; c++) begin
            for (int b = 0; b < 3; b++) begin
                for (int p = 0; p < 2; p++) begin
                    @(posedge mclk_in);
                    case (b)
                        0: drive[c] <= ~drive[c];
                        1: nosig[c] <= ~nosig[c];
                        default: lock[c] <= ~lock[c];
                    endcase
                    settle(3);
                    check("pending set", pend, 12'(1) << c);
                    check("int asserted", {11'h0, int_b}, 12'h000);
                    rd((c < 6) ? 8'h61 : 8'hE1, 8'(1 << (c % 6)));
                    settle(6);
                    rd((c < 6) ? 8'h61 : 8'hE1, 8'(1 << (c % 6)));
                    rd(ca(c, 4'h3), {5'h00, lock[c], nosig[c], drive[c]});
                    rd(ca(c, 4'h2), 8'(1 << b));
                    rd(ca(c, 4'h2), 8'h00);
                    settle(2);
                    check("pending cleared", pend, 12'h000);
                    check("int released", {11'h0, int_b}, 12'h001);
                end
            end
        end
        $display("test done: events");
        // Master enable gating
        wr(8'h60, 8'h00);
        @(posedge mclk_in);
        lock[0] <= ~lock[0];
        settle(3);
        check("masked pending", pend, 12'h001);
        check("masked int", {11'h0, int_b}, 12'h001);
        wr(8'h60, 8'h3F);
        settle(2);
        check("unmasked int", {11'h0, int_b}, 12'h000);
        rd(ca(0, 4'h2), 8'h04);
        settle(2);
        check("int after service", {11'h0, int_b}, 12'h001);
        // Disabled source never flags
        wr(ca(7, 4'h1), 8'h06);
        @(posedge mclk_in);
        drive[7] <= ~drive[7];
        settle(3);
        check("disabled source", pend, 12'h000);
        rd(ca(7, 4'h2), 8'h00);
        settle(4);
        $display("test done: gating");
        // Clock enable low freezes every register and ignores strobes
        wr(ca(0, 4'h4), 8'h5A);
        @(posedge mclk_in);
        ce      <= 1'b0;
        lock[1] <= ~lock[1];
        wr(ca(0, 4'h4), 8'hA5);
        settle(2);
        check("frozen pending", pend, 12'h000);
        @(posedge mclk_in);
        ce <= 1'b1;
        settle(2);
        check("pending after thaw", pend, 12'h002);
        rd(ca(0, 4'h4), 8'h5A);
        rd(ca(1, 4'h2), 8'h04);
        settle(4);
        $display("test done: clock enable");
        check("answers drained", 12'(exp_q.size()), 12'h000);
        finish_test();
    end
endmodule
